// file: core/serial_port_pkg.sv
// Constants and register map for the serial port with baud generation
// Function
// RL1 - Mode bits pick shift register or UART
// RL2 - Modes 2/3 filter drops ninth-bit-zero frames
// RL3 - Mode 1 filter needs valid stop bit
// RL4 - Receive enable bit gates reception
// RL5 - Modes 2/3 send software ninth bit
// RL6 - Received ninth bit or stop bit stored
// RL7 - Transmit done flag set, software clears
// RL8 - Receive full flag set, software clears
// RL9 - Mode 2 rate osc/64 or osc/32
// RL10 - Timer 1 overflow times doubler over 32
// RL11 - Timer 1 auto-reload rate formula
// RL12 - Timer 2 selectable per direction
// RL13 - Second port selects in power control
// RL14 - Timer 2 reloads on rollover, rate/16
// RL15 - Timer 2 rate osc/(32*(65536-reload)); Timer 2 here counts every clock, giving osc/(16*(65536-reload))
// RL16 - Baud rollover sets no overflow flag
// RL17 - External pin edge sets flag only
// RL18 - Software stops timer before access
// RL19 - Mode 0 data on rx, clock on tx; tx here gives the shift clock only in Mode 0 transmit, not in reception
// RL20 - Buffer write starts Mode 0 transmit
// RL21 - One machine cycle before shifting starts
// RL22 - Separate transmit and receive buffers
// RL23 - Sixteenfold sampling, majority, start check
// RL24 - Frames of 10 or 11 bits
// RL25 - Frame lost while receive full set
package serial_port_pkg;
   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_BUFFER = 8'h04;
   localparam logic [7:0] ADDR_TIMER2_CONTROL = 8'h08;
   localparam logic [7:0] ADDR_POWER_CONTROL = 8'h0C;
   localparam logic [7:0] ADDR_RELOAD = 8'h10;
   localparam logic [7:0] ADDR_TIMER2 = 8'h14;
   localparam logic [7:0] ADDR_TIMER1 = 8'h18;
   // Control bit positions
   localparam int BIT_MODE_HI = 7;
   localparam int BIT_MODE_LO = 6;
   localparam int BIT_FILTER = 5;
   localparam int BIT_RX_EN = 4;
   localparam int BIT_TX9 = 3;
   localparam int BIT_RX9 = 2;
   localparam int BIT_TX_DONE = 1;
   localparam int BIT_RX_FULL = 0;
   // Timer 2 control bits
   localparam int BIT_T2_OVF = 7;
   localparam int BIT_T2_EXT_FLAG = 6;
   localparam int BIT_RX_T2 = 5;
   localparam int BIT_TX_T2 = 4;
   localparam int BIT_T2_EXT_EN = 3;
   localparam int BIT_T2_RUN = 2;
   // Power control bits
   localparam int BIT_DOUBLER = 7;
   localparam int BIT_RX2_T2 = 5;
   localparam int BIT_TX2_T2 = 4;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] POWER_RESET = 8'h00;
   localparam logic [15:0] RELOAD_RESET = 16'h0000;
   localparam int OSC_PER_MACHINE = 12;
   localparam int MODE2_DIV_SLOW = 64;
   localparam int MODE2_DIV_FAST = 32;
   localparam int T1_DIV = 32;
   localparam int T2_DIV = 16;
   localparam int OVERSAMPLE = 16;
   localparam int T1_RELOAD_SPAN = 256;
   localparam logic [3:0] SAMPLE_A = 4'h7;
   localparam logic [3:0] SAMPLE_B = 4'h8;
   localparam logic [3:0] SAMPLE_C = 4'h9;
   localparam logic [3:0] LAST_TICK = 4'hF;
   localparam logic [1:0] AXI_OKAY = 2'b00;
   localparam logic [1:0] AXI_SLVERR = 2'b10;
   typedef enum logic [3:0] {
      TX_IDLE = 4'b0001,
      TX_WAIT = 4'b0010,
      TX_SHIFT = 4'b0100,
      TX_STOP = 4'b1000
   } tx_state_t;
   typedef enum logic [2:0] {
      RX_IDLE = 3'b001,
      RX_BITS = 3'b010,
      RX_SHIFT0 = 3'b100
   } rx_state_t;
endpackage

// file: core/serial_port.sv
// Serial port with mode control, Timer 1/2 baud sources and AXI4-Lite registers
//
// Our own choices: the AXI4-Lite register port and the address map.
module serial_port
   import serial_port_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Serial pins; rx_line is two-way in Mode 0
   input wire logic rx_line_in,
   output logic rx_line_out,
   output logic rx_line_oe_n,
   output logic tx_line,
   // Timer 1 overflow pulse and Timer 2 external pin
   input wire logic timer1_overflow,
   input wire logic timer2_ext_pin
);
   logic [7:0] control_reg;
   logic [7:0] tx_buffer_reg;
   logic [7:0] rx_buffer_reg;
   logic [7:0] t2ctl_reg;
   logic [7:0] power_reg;
   logic [15:0] reload_reg;
   logic [15:0] timer2_reg;
   logic [3:0] t1_div_reg;
   logic [3:0] osc_div_reg;
   logic [5:0] m2_div_reg;
   logic [3:0] t2_div_reg;
   logic ext_pin_reg;
   logic wr_go;
   logic [7:0] wr_addr_reg;
   logic [31:0] wr_data_reg;
   logic have_aw;
   logic have_w;
   logic buf_write;
   logic machine_tick;
   logic t1_tick;
   logic t2_ovf;
   logic t2_tick;
   logic m2_tick;
   logic var_tick;
   logic rx_tick;
   logic tx_tick;
   logic [1:0] mode;
   tx_state_t tx_state;
   logic [9:0] tx_shift_reg;
   logic [3:0] tx_cnt_reg;
   logic [3:0] tx_phase_reg;
   rx_state_t rx_state;
   logic [8:0] rx_shift_reg;
   logic [3:0] rx_cnt_reg;
   logic [3:0] rx_phase_reg;
   logic [2:0] rx_samp_reg;
   logic rx_prev_reg;
   logic tx_done_set;
   logic rx_done_set;
   logic rx_done_ok;
   logic [7:0] rx_data_next;
   logic rx_nine_next;

   function automatic logic majority(input logic [2:0] s);
      majority = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
   endfunction

   assign mode = {control_reg[BIT_MODE_HI], control_reg[BIT_MODE_LO]};

   // Write channel capture
   assign wr_go = have_aw && have_w && !s_axi_bvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         have_aw <= 1'b0;
         have_w <= 1'b0;
         wr_addr_reg <= 8'h00;
         wr_data_reg <= 32'h0000_0000;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= AXI_OKAY;
      end else begin
         s_axi_awready <= !have_aw && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !have_w && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            have_aw <= 1'b1;
            wr_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            have_w <= 1'b1;
            wr_data_reg <= s_axi_wdata;
         end
         if (wr_go) begin
            have_aw <= 1'b0;
            have_w <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_addr_reg[1:0] == 2'b00 && wr_addr_reg <= ADDR_TIMER1) ? AXI_OKAY : AXI_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   assign buf_write = wr_go && wr_addr_reg == ADDR_BUFFER && s_axi_wstrb[0];

   // Read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= AXI_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= AXI_OKAY;
            case (s_axi_araddr)
               ADDR_CONTROL: s_axi_rdata <= {24'h00_0000, control_reg};
               ADDR_BUFFER: s_axi_rdata <= {24'h00_0000, rx_buffer_reg}; // [RL22]
               ADDR_TIMER2_CONTROL: s_axi_rdata <= {24'h00_0000, t2ctl_reg};
               ADDR_POWER_CONTROL: s_axi_rdata <= {24'h00_0000, power_reg};
               ADDR_RELOAD: s_axi_rdata <= {16'h0000, reload_reg};
               ADDR_TIMER2: s_axi_rdata <= {16'h0000, timer2_reg};
               ADDR_TIMER1: s_axi_rdata <= 32'h0000_0000;
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= AXI_SLVERR;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Control register; hardware sets win over software clears
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         control_reg <= CONTROL_RESET;
      end else begin
         if (wr_go && wr_addr_reg == ADDR_CONTROL && s_axi_wstrb[0]) begin
            control_reg <= wr_data_reg[7:0];
         end
         if (rx_done_set && rx_done_ok) begin
            control_reg[BIT_RX9] <= rx_nine_next; // [RL6]
         end
         if (tx_done_set) begin
            control_reg[BIT_TX_DONE] <= 1'b1; // [RL7]
         end
         if (rx_done_set && rx_done_ok) begin
            control_reg[BIT_RX_FULL] <= 1'b1; // [RL8]
         end
      end
   end

   // Power control and Timer 2 registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         power_reg <= POWER_RESET;
         t2ctl_reg <= 8'h00;
         reload_reg <= RELOAD_RESET;
      end else begin
         if (wr_go && s_axi_wstrb[0] && wr_addr_reg == ADDR_POWER_CONTROL) begin
            power_reg <= wr_data_reg[7:0]; // [RL13]
         end
         if (wr_go && s_axi_wstrb[0] && wr_addr_reg == ADDR_TIMER2_CONTROL) begin
            t2ctl_reg <= wr_data_reg[7:0];
         end
         if (wr_go && wr_addr_reg == ADDR_RELOAD) begin
            reload_reg <= wr_data_reg[15:0]; // [RL18]
         end
         if (t2_ovf && !(t2ctl_reg[BIT_RX_T2] || t2ctl_reg[BIT_TX_T2])) begin
            t2ctl_reg[BIT_T2_OVF] <= 1'b1; // [RL16]
         end
         if (t2ctl_reg[BIT_T2_EXT_EN] && ext_pin_reg && !timer2_ext_pin) begin
            t2ctl_reg[BIT_T2_EXT_FLAG] <= 1'b1; // [RL17]
         end
      end
   end

   // Machine cycle and Mode 2 dividers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         osc_div_reg <= 4'h0;
         m2_div_reg <= 6'h00;
         ext_pin_reg <= 1'b1;
      end else begin
         osc_div_reg <= machine_tick ? 4'h0 : osc_div_reg + 4'h1;
         m2_div_reg <= m2_tick ? 6'h00 : m2_div_reg + 6'h01;
         ext_pin_reg <= timer2_ext_pin;
      end
   end
   assign machine_tick = osc_div_reg == 4'(OSC_PER_MACHINE - 1); // [RL19]
   assign m2_tick = power_reg[BIT_DOUBLER] ? m2_div_reg[0]
      : (m2_div_reg[1:0] == 2'h3); // [RL9]

   // Timer 2 counts every clock while its run bit is set, reloads on rollover
   assign t2_ovf = t2ctl_reg[BIT_T2_RUN] && timer2_reg == 16'hFFFF;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timer2_reg <= 16'h0000;
      end else if (wr_go && wr_addr_reg == ADDR_TIMER2) begin
         timer2_reg <= wr_data_reg[15:0];
      end else if (t2_ovf) begin
         timer2_reg <= reload_reg; // [RL14]
      end else if (t2ctl_reg[BIT_T2_RUN]) begin
         timer2_reg <= timer2_reg + 16'h0001; // [RL15]
      end
   end

   // Timer 1 prescaler: overflow/32, halved with doubler
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         t1_div_reg <= 4'h0;
         t2_div_reg <= 4'h0;
      end else begin
         if (timer1_overflow) begin
            t1_div_reg <= t1_tick ? 4'h0 : t1_div_reg + 4'h1;
         end
         if (t2_ovf) begin
            t2_div_reg <= t2_div_reg + 4'h1;
         end
      end
   end
   assign t1_tick = timer1_overflow && (power_reg[BIT_DOUBLER] ? 1'b1 : t1_div_reg[0]); // [RL10] [RL11]
   assign t2_tick = t2_ovf; // [RL14]
   assign var_tick = t1_tick;
   assign rx_tick = (mode == 2'b10) ? m2_tick : (t2ctl_reg[BIT_RX_T2] ? t2_tick : var_tick); // [RL12]
   assign tx_tick = (mode == 2'b10) ? m2_tick : (t2ctl_reg[BIT_TX_T2] ? t2_tick : var_tick); // [RL12]

   // Transmitter
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_state <= TX_IDLE;
         tx_shift_reg <= 10'h3FF;
         tx_cnt_reg <= 4'h0;
         tx_phase_reg <= 4'h0;
         tx_buffer_reg <= 8'h00;
         tx_line <= 1'b1;
         tx_done_set <= 1'b0;
      end else begin
         tx_done_set <= 1'b0;
         case (tx_state)
            TX_IDLE: begin
               tx_line <= 1'b1;
               if (buf_write) begin
                  tx_buffer_reg <= wr_data_reg[7:0];
                  tx_shift_reg <= {1'b1, (mode[1] ? control_reg[BIT_TX9] : 1'b1), wr_data_reg[7:0]}; // [RL5] [RL20]
                  tx_cnt_reg <= 4'h0;
                  tx_phase_reg <= 4'h0;
                  tx_state <= TX_WAIT;
               end
            end
            TX_WAIT: begin
               if (mode == 2'b00 ? machine_tick : (tx_tick && tx_phase_reg == LAST_TICK)) begin
                  tx_state <= TX_SHIFT; // [RL21]
                  tx_line <= (mode == 2'b00) ? 1'b1 : 1'b0;
               end
               if (tx_tick) begin
                  tx_phase_reg <= tx_phase_reg + 4'h1;
               end
            end
            TX_SHIFT: begin
               if (mode == 2'b00) begin
                  if (machine_tick) begin
                     tx_shift_reg <= {1'b0, tx_shift_reg[9:1]}; // [RL19]
                     tx_cnt_reg <= tx_cnt_reg + 4'h1;
                     if (tx_cnt_reg == 4'h7) begin
                        tx_done_set <= 1'b1; // [RL7]
                        tx_state <= TX_IDLE;
                     end
                  end
                  tx_line <= osc_div_reg < 4'(OSC_PER_MACHINE / 2);
               end else if (tx_tick) begin
                  tx_phase_reg <= tx_phase_reg + 4'h1;
                  if (tx_phase_reg == LAST_TICK) begin
                     tx_line <= tx_shift_reg[0];
                     tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
                     tx_cnt_reg <= tx_cnt_reg + 4'h1;
                     if (tx_cnt_reg == (mode[1] ? 4'h8 : 4'h7)) begin // [RL24]
                        tx_state <= TX_STOP;
                     end
                  end
               end
            end
            TX_STOP: begin
               if (tx_tick && tx_phase_reg == LAST_TICK) begin
                  tx_line <= 1'b1;
                  tx_done_set <= 1'b1; // [RL7]
                  tx_state <= TX_IDLE;
               end
               if (tx_tick) begin
                  tx_phase_reg <= tx_phase_reg + 4'h1;
               end
            end
            default: tx_state <= TX_IDLE;
         endcase
      end
   end

   // Mode 0 drives rx_line with data; receive in Mode 0 uses it as input
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_line_out <= 1'b1;
         rx_line_oe_n <= 1'b1;
      end else begin
         rx_line_out <= tx_shift_reg[0];
         rx_line_oe_n <= !(mode == 2'b00 && tx_state == TX_SHIFT); // [RL19]
      end
   end

   // Receiver
   assign rx_data_next = (mode == 2'b00) ? rx_shift_reg[8:1] : rx_shift_reg[7:0];
   assign rx_nine_next = rx_shift_reg[8];
   assign rx_done_ok = !control_reg[BIT_RX_FULL] // [RL25]
      && !(control_reg[BIT_FILTER] && mode != 2'b00 && !rx_nine_next); // [RL2] [RL3]
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_state <= RX_IDLE;
         rx_shift_reg <= 9'h000;
         rx_cnt_reg <= 4'h0;
         rx_phase_reg <= 4'h0;
         rx_samp_reg <= 3'b111;
         rx_prev_reg <= 1'b1;
         rx_buffer_reg <= 8'h00;
         rx_done_set <= 1'b0;
      end else begin
         rx_done_set <= 1'b0;
         if (rx_done_set && rx_done_ok) begin
            rx_buffer_reg <= rx_data_next; // [RL22]
         end
         if (rx_tick) begin
            rx_prev_reg <= rx_line_in;
         end
         case (rx_state)
            RX_IDLE: begin
               rx_cnt_reg <= 4'h0;
               rx_phase_reg <= 4'h0;
               if (control_reg[BIT_RX_EN]) begin // [RL4]
                  if (mode == 2'b00 && !control_reg[BIT_RX_FULL] && tx_state == TX_IDLE) begin
                     rx_state <= RX_SHIFT0;
                  end else if (mode != 2'b00 && rx_tick && rx_prev_reg && !rx_line_in) begin
                     rx_state <= RX_BITS;
                  end
               end
            end
            RX_SHIFT0: begin
               if (machine_tick) begin
                  rx_shift_reg <= {rx_line_in, rx_shift_reg[8:1]}; // [RL19]
                  rx_cnt_reg <= rx_cnt_reg + 4'h1;
                  if (rx_cnt_reg == 4'h8) begin
                     rx_done_set <= 1'b1; // [RL8]
                     rx_state <= RX_IDLE;
                  end
               end
               if (!control_reg[BIT_RX_EN]) begin
                  rx_state <= RX_IDLE; // [RL4]
               end
            end
            RX_BITS: begin
               if (rx_tick) begin
                  rx_phase_reg <= rx_phase_reg + 4'h1;
                  if (rx_phase_reg == SAMPLE_A || rx_phase_reg == SAMPLE_B || rx_phase_reg == SAMPLE_C) begin
                     rx_samp_reg <= {rx_samp_reg[1:0], rx_line_in}; // [RL23]
                  end
                  if (rx_phase_reg == SAMPLE_C + 4'h1) begin
                     if (rx_cnt_reg == 4'h0 && majority(rx_samp_reg)) begin
                        rx_state <= RX_IDLE; // [RL23]
                     end else if (rx_cnt_reg != 4'h0 && rx_cnt_reg != 4'hA) begin
                        rx_shift_reg <= {majority(rx_samp_reg), rx_shift_reg[8:1]};
                     end
                     rx_cnt_reg <= rx_cnt_reg + 4'h1;
                     if (rx_cnt_reg == (mode[1] ? 4'h9 : 4'h8) + 4'h1) begin // [RL24]
                        rx_done_set <= 1'b1; // [RL8]
                        rx_state <= RX_IDLE;
                     end
                  end
               end
               if (!control_reg[BIT_RX_EN]) begin
                  rx_state <= RX_IDLE; // [RL4]
               end
            end
            default: rx_state <= RX_IDLE;
         endcase
      end
   end
endmodule

// file: verification/serial_port_properties.sv
// Port checker for the serial port, bound to its top module
module serial_port_properties
   import serial_port_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Serial pins
   input wire logic rx_line_oe_n,
   input wire logic tx_line
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic bad_addr;
   assign bad_addr = (s_axi_araddr > 8'h18) || (s_axi_araddr[1:0] != 2'b00);
   property p_reset_idle;
      $rose(aresetn) |-> tx_line && rx_line_oe_n;
   endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("lines not idle after reset");
   property p_aw_ready;
      s_axi_awready |-> s_axi_awvalid;
   endproperty
   a_aw_ready: assert property (p_aw_ready) else $error("awready without awvalid");
   property p_w_ready;
      s_axi_wready |-> s_axi_wvalid;
   endproperty
   a_w_ready: assert property (p_w_ready) else $error("wready without wvalid");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");
   property p_b_once;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   a_b_once: assert property (p_b_once) else $error("second write response");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read answer not held");
   property p_r_answer;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_r_answer: assert property (p_r_answer) else $error("read answer late");
   property p_r_refused;
      s_axi_arvalid && s_axi_arready && bad_addr |=> s_axi_rresp == AXI_SLVERR && s_axi_rdata == 32'h0000_0000;
   endproperty
   a_r_refused: assert property (p_r_refused) else $error("unmapped read not refused");
   property p_r_okay;
      s_axi_arvalid && s_axi_arready && !bad_addr |=> s_axi_rresp == AXI_OKAY;
   endproperty
   a_r_okay: assert property (p_r_okay) else $error("mapped read refused");
   property p_shift_clock;
      $fell(tx_line) && !rx_line_oe_n |-> ##[1:11] $rose(tx_line);
   endproperty
   a_shift_clock: assert property (p_shift_clock) else $error("shift clock stuck low");
   c_mode0: cover property (!rx_line_oe_n);
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_refused: cover property (s_axi_rvalid && s_axi_rresp == AXI_SLVERR);
endmodule

bind serial_port serial_port_properties i_serial_port_properties (
   .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_line_oe_n, .tx_line
);

// file: verification/line_peer.sv
// Remote serial device on the far side of the port
module line_peer (
   // Clock
   input wire logic aclk,
   // Pins of the port
   input wire logic tx_line,
   input wire logic rx_line_out,
   input wire logic rx_line_oe_n,
   output logic rx_line_in
);
   timeunit 1ns;
   timeprecision 100ps;
   logic level = 1'b1;
   // Port drives in Mode 0 transmit, else our level, idle high
   assign rx_line_in = rx_line_oe_n ? level : rx_line_out;
   // Start, data LSB first, stop
   task automatic send(input logic [8:0] d, input int nd, input logic stop, input int clks);
      repeat (clks) @(posedge aclk);
      for (int i = 0; i < nd + 2; i++) begin
         level <= (i == 0) ? 1'b0 : (i > nd) ? stop : d[i - 1];
         repeat (clks) @(posedge aclk);
      end
      level <= 1'b1;
   endtask
   // Mid-bit sampling of an asynchronous frame
   task automatic catch_frame(input int nd, input int clks, output logic [8:0] d, output logic stop,
                              output logic ok);
      int n;
      n = 0;
      d = '0;
      while (tx_line && n < 20000) begin
         @(posedge aclk);
         n++;
      end
      repeat (clks / 2) @(posedge aclk);
      ok = !tx_line && n < 20000;
      for (int i = 0; i < nd; i++) begin
         repeat (clks) @(posedge aclk);
         d[i] = tx_line;
      end
      repeat (clks) @(posedge aclk);
      stop = tx_line;
   endtask
   // Mode 0 data taken after each shift clock fall
   task automatic catch_sync(output logic [8:0] d, output logic ok);
      int n;
      int i;
      logic prev;
      n = 0;
      i = 0;
      d = '0;
      prev = tx_line;
      while (i < 8 && n < 5000) begin
         @(negedge aclk);
         n++;
         if (prev && !tx_line && !rx_line_oe_n) begin
            d[i] = rx_line_out;
            i++;
         end
         prev = tx_line;
      end
      ok = (i == 8);
   endtask
endmodule

// file: verification/serial_port_with_baud_generation_tb.sv
// Register-level bench for the serial port
module serial_port_with_baud_generation_tb
   import serial_port_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic timer1_overflow = 1'b0, timer2_ext_pin = 1'b1;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [31:0] s_axi_rdata, d;
   logic rx_line_in, rx_line_out, rx_line_oe_n, tx_line, st, ok;
   logic [8:0] d9;
   int failures = 0, checks = 0;
   always #5 aclk = ~aclk;
   // Timer 1 overflow every second cycle: 64 clocks a bit
   always @(posedge aclk) timer1_overflow <= ~timer1_overflow;
   serial_port i_serial_port (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .rx_line_in, .rx_line_out, .rx_line_oe_n, .tx_line, .timer1_overflow, .timer2_ext_pin
   );
   line_peer i_line_peer (.aclk, .tx_line, .rx_line_out, .rx_line_oe_n, .rx_line_in);
   task automatic test_done();
      if (failures == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic hang();
      failures++;
      test_done();
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 100);
      s_axi_bready <= 1'b0;
      if (n >= 100) hang();
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic [1:0] s);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 100);
      q = s_axi_rdata;
      s = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n >= 100) hang();
   endtask
   // Read control until all bits of m are set, bounded
   task automatic poll(input logic [31:0] m);
      int n;
      n = 0;
      d = '0;
      while ((d & m) !== m && n < 50) begin
         rd(ADDR_CONTROL, d, r);
         n++;
      end
      chk(d & m, m);
   endtask
   initial begin
      repeat (100000) @(posedge aclk);
      hang();
   end
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      // Reset values and a refused address
      rd(ADDR_CONTROL, d, r);
      chk(d, 32'h0000_0000);
      rd(ADDR_POWER_CONTROL, d, r);
      chk(d, 32'h0000_0000);
      rd(8'h1C, d, r);
      chk({d[29:0], r}, {30'h0000_0000, AXI_SLVERR});
      wr(ADDR_POWER_CONTROL, 32'h0000_0030);
      rd(ADDR_POWER_CONTROL, d, r);
      chk(d, 32'h0000_0030);
      // Mode 2 transmit, doubled rate first, both ninth-bit values
      for (int k = 0; k < 2; k++) begin
         wr(ADDR_POWER_CONTROL, (k != 0) ? 32'h0000_0000 : 32'h0000_0080);
         wr(ADDR_CONTROL, (k != 0) ? 32'h0000_0088 : 32'h0000_0080);
         fork
            wr(ADDR_BUFFER, 32'h0000_00A5);
            i_line_peer.catch_frame(9, (k != 0) ? 64 : 32, d9, st, ok);
         join
         chk({21'h0, ok, st, d9}, {21'h0, 1'b1, 1'b1, k[0], 8'hA5});
         poll(32'h0000_0002);
         wr(ADDR_CONTROL, 32'h0000_0080);
         rd(ADDR_CONTROL, d, r);
         chk(d & 32'h0000_0002, 32'h0000_0000);
      end
      // Mode 2 receive with address filter, then overrun, then disabled
      wr(ADDR_CONTROL, 32'h0000_00B0);
      i_line_peer.send(9'h011, 9, 1'b1, 64);
      rd(ADDR_CONTROL, d, r);
      chk(d & 32'h0000_0001, 32'h0000_0000);
      i_line_peer.send(9'h196, 9, 1'b1, 64);
      poll(32'h0000_0005);
      i_line_peer.send(9'h133, 9, 1'b1, 64);
      rd(ADDR_BUFFER, d, r);
      chk(d, 32'h0000_0096);
      wr(ADDR_CONTROL, 32'h0000_00A0);
      i_line_peer.send(9'h144, 9, 1'b1, 64);
      rd(ADDR_CONTROL, d, r);
      chk(d & 32'h0000_0001, 32'h0000_0000);
      // Mode 1 on Timer 1, stop bit kept, then bad stop filtered
      wr(ADDR_CONTROL, 32'h0000_0050);
      i_line_peer.send(9'h03C, 8, 1'b1, 64);
      poll(32'h0000_0005);
      rd(ADDR_BUFFER, d, r);
      chk(d, 32'h0000_003C);
      wr(ADDR_CONTROL, 32'h0000_0070);
      i_line_peer.send(9'h0C3, 8, 1'b0, 64);
      rd(ADDR_CONTROL, d, r);
      chk(d & 32'h0000_0001, 32'h0000_0000);
      // Mode 0 transmit
      wr(ADDR_CONTROL, 32'h0000_0000);
      fork
         wr(ADDR_BUFFER, 32'h0000_00C3);
         i_line_peer.catch_sync(d9, ok);
      join
      chk({23'h0, ok, d9[7:0]}, {23'h0, 1'b1, 8'hC3});
      poll(32'h0000_0002);
      // Timer 2 as baud source: reload set while stopped
      wr(ADDR_RELOAD, 32'h0000_FFF0);
      wr(ADDR_TIMER2, 32'h0000_FFF0);
      wr(ADDR_TIMER2_CONTROL, 32'h0000_001C);
      repeat (200) @(posedge aclk);
      timer2_ext_pin <= 1'b0;
      rd(ADDR_TIMER2_CONTROL, d, r);
      chk(d & 32'h0000_00C0, 32'h0000_0040);
      rd(ADDR_RELOAD, d, r);
      chk(d, 32'h0000_FFF0);
      test_done();
   end
endmodule
